// [overtemp_defs.svh]
// Functional notes
// R1: upper seven timer bits zero until 45.52ms
// R2: bit0 set on assertion, cleared by read
// R3: past 45.52ms bit0 joins eight-bit count; code shows count bits 7:1 with bit0 held at 1
// R4: count steps 22.76ms, covers up to 5.82s
// R5: writable eight-bit duration limit, 22.76ms step
// R6: duration over limit sets exceeded status flag
// R7: limit zero flags immediately on assertion
// R8: four pulse-count fields, reset 0x55
// R9: config bit0 selects twos or offset-64 format
// R10: config bit1 selects offset register range
// R11: config bit2 sets aux pin direction
// R12: config bit3 sets aux output polarity
// R13: config bit4 picks id or general pins
// R14: bits 5-7 enable per-channel line driving
// R15: channel disabled by minimum limit value
// R16: config read-only when lock set, reset 0x01
// R17: global off suppresses all overtemp outputs
// R18: duration count saturates at all ones
// R19: timer ticks every 22.76ms, compared per tick
`ifndef OVERTEMP_DEFS_SVH
`define OVERTEMP_DEFS_SVH
`define ADDR_DURATION     8'h79
`define ADDR_LIMIT        8'h7a
`define ADDR_PULSES       8'h7b
`define ADDR_CONFIG       8'h7c
`define ADDR_IRQ_STATUS   8'h42
`define ADDR_IRQ_MASK     8'h43
`define ADDR_CONTROL      8'h44
`define RST_PULSES        8'h55
`define RST_CONFIG        8'h01
`define CLK_HZ            50000000
`define TICK_US           22760
`define TICK_CYCLES       ((`CLK_HZ / 1000000) * `TICK_US)
`define CFG_TWOS          0
`define CFG_OFFSET_RANGE  1
`define CFG_AUX_DIR       2
`define CFG_AUX_POL       3
`define CFG_ID_SEL        4
`define CFG_EN_R1         5
`define CFG_EN_LOCAL      6
`define CFG_EN_R2         7
`define IRQ_EXCEEDED      5
`define IRQ_ASSERT        0
`define LIMIT_OFF64_MIN   8'h00
`define LIMIT_TWOS_MIN    8'h80
`endif

// [overtemp_pkg.sv]
package overtemp_pkg;
    typedef enum logic [1:0] {
        idle_st    = 2'b00,
        timing_st  = 2'b01
    } timer_state_type;
endpackage : overtemp_pkg

// [sync_two_ff.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff (
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic stage1_reg;
    logic stage2_reg;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end
    assign sync_o = stage2_reg;
endmodule : sync_two_ff
`default_nettype wire

// [tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
`include "overtemp_defs.svh"
module tick_divider #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    input  wire logic restart_i,
    output logic      tick_o
);
    logic [20:0] count_reg;
    logic [20:0] count_next;
    logic        tick_next;
    logic        tick_reg;
    always_comb begin
        count_next = count_reg + 21'h000001;
        tick_next  = 1'b0;
        if (restart_i) begin
            count_next = 21'h000000;
        end else if (count_reg >= 21'(TICK_CYCLES - 1)) begin
            count_next = 21'h000000;
            tick_next  = 1'b1;
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            count_reg <= 21'h000000;
            tick_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg  <= tick_next;
        end
    end
    assign tick_o = tick_reg;
endmodule : tick_divider
`default_nettype wire

// [overtemp_timer_fan_config.sv]
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "overtemp_defs.svh"
module overtemp_timer_fan_config #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        overtemp_line_i,
    output logic             overtemp_line_o,
    output logic             overtemp_line_oe_n_o,
    input  wire logic [2:0]  channel_over_limit_i,
    input  wire logic [23:0] channel_limit_i,
    input  wire logic        lock_i,
    input  wire logic        overtemp_global_off_i,
    input  wire logic        aux_pin_six_i,
    output logic             aux_pin_six_o,
    output logic             aux_pin_six_oe_n_o,
    input  wire logic        aux_pin_value_i,
    output logic             twos_format_select_o,
    output logic             offset_range_select_o,
    output logic             id_pins_function_select_o,
    output logic [7:0]       fan_pulses_per_rev_o,
    output logic             aux_pin_six_level_o,
    output logic             irq_o
);
    logic line_sync;
    logic tick;
    sync_two_ff line_sync_inst (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (~overtemp_line_i),
        .sync_o    (line_sync)
    );
    logic aux_sync;
    sync_two_ff aux_sync_inst (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (aux_pin_six_i),
        .sync_o    (aux_sync)
    );
    // line inverted ahead of sync so reset reads as idle, no false edge
    logic asserted;
    logic line_prev_reg;
    logic rise;
    assign asserted = line_sync;
    assign rise     = asserted & ~line_prev_reg;
    tick_divider #(
        .TICK_CYCLES (TICK_CYCLES)
    ) tick_inst (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .restart_i (rise),
        .tick_o    (tick)
    );
    // bus decode
    logic req;
    logic wr;
    logic rd;
    logic mapped;
    logic wr_lane0;
    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign mapped   = (wb_adr_i == `ADDR_DURATION) | (wb_adr_i == `ADDR_LIMIT) |
                      (wb_adr_i == `ADDR_PULSES) | (wb_adr_i == `ADDR_CONFIG) |
                      (wb_adr_i == `ADDR_IRQ_STATUS) | (wb_adr_i == `ADDR_IRQ_MASK) |
                      (wb_adr_i == `ADDR_CONTROL);
    assign wr       = req & mapped & wb_we_i;
    assign rd       = req & mapped & ~wb_we_i;
    assign wr_lane0 = wr & wb_sel_i[0];
    // registers
    overtemp_pkg::timer_state_type state_reg;
    overtemp_pkg::timer_state_type state_next;
    logic [7:0]  ticks_reg;
    logic [7:0]  ticks_next;
    logic        seen_reg;
    logic        seen_next;
    logic [7:0]  limit_reg;
    logic [7:0]  limit_next;
    logic [7:0]  pulses_reg;
    logic [7:0]  pulses_next;
    logic [7:0]  config_reg;
    logic [7:0]  config_next;
    logic [7:0]  irq_status_reg;
    logic [7:0]  irq_status_next;
    logic [7:0]  irq_mask_reg;
    logic [7:0]  irq_mask_next;
    logic        exceeded_done_reg;
    logic        exceeded_done_next;
    logic        ack_next;
    logic        err_next;
    logic [31:0] dat_next;
    logic [31:0] dat_reg;
    logic [7:0]  duration_view;
    logic        long_enough;
    // two ticks is 45.52 ms
    assign long_enough = (ticks_reg >= 8'h02);
    // [R1] [R3]
    assign duration_view = long_enough ? {ticks_reg[7:1], 1'b1} : {7'h00, seen_reg};
    always_comb begin
        state_next         = state_reg;
        ticks_next         = ticks_reg;
        seen_next          = seen_reg;
        exceeded_done_next = exceeded_done_reg;
        unique case (state_reg)
            overtemp_pkg::idle_st: begin
                if (rise) begin
                    state_next         = overtemp_pkg::timing_st;
                    ticks_next         = 8'h00;
                    exceeded_done_next = 1'b0;
                end
            end
            overtemp_pkg::timing_st: begin
                if (!asserted) begin
                    state_next = overtemp_pkg::idle_st;
                end else if (tick && ticks_reg != 8'hff) begin
                    ticks_next = ticks_reg + 8'h01; // [R4] [R18] [R19]
                end
            end
        endcase
        if (rd && wb_adr_i == `ADDR_DURATION) begin
            seen_next = 1'b0; // [R2]
        end
        if (rise) begin
            seen_next = 1'b1; // [R2]
        end
    end
    logic exceeded_evt;
    always_comb begin
        exceeded_evt = 1'b0;
        if (limit_reg == 8'h00) begin
            exceeded_evt = rise; // [R7]
        end else if (state_reg == overtemp_pkg::timing_st && asserted && !exceeded_done_reg &&
                     ticks_reg > limit_reg) begin
            exceeded_evt = 1'b1; // [R6]
        end
    end
    always_comb begin
        limit_next      = limit_reg;
        pulses_next     = pulses_reg;
        config_next     = config_reg;
        irq_mask_next   = irq_mask_reg;
        irq_status_next = irq_status_reg;
        if (wr_lane0 && wb_adr_i == `ADDR_LIMIT) begin
            limit_next = wb_dat_i[7:0]; // [R5]
        end
        if (wr_lane0 && wb_adr_i == `ADDR_PULSES) begin
            pulses_next = wb_dat_i[7:0]; // [R8]
        end
        if (wr_lane0 && wb_adr_i == `ADDR_CONFIG && !lock_i) begin
            config_next = wb_dat_i[7:0]; // [R16]
        end
        if (wr_lane0 && wb_adr_i == `ADDR_IRQ_MASK) begin
            irq_mask_next = wb_dat_i[7:0];
        end
        if (wr_lane0 && wb_adr_i == `ADDR_IRQ_STATUS) begin
            irq_status_next = irq_status_reg & ~wb_dat_i[7:0];
        end
        if (exceeded_evt) begin
            irq_status_next[`IRQ_EXCEEDED] = 1'b1; // [R6]
        end
        if (rise) begin
            irq_status_next[`IRQ_ASSERT] = 1'b1;
        end
    end
    always_comb begin
        dat_next = 32'h00000000;
        ack_next = req & mapped;
        err_next = req & ~mapped;
        unique case (wb_adr_i)
            `ADDR_DURATION:   dat_next[7:0] = duration_view;
            `ADDR_LIMIT:      dat_next[7:0] = limit_reg;
            `ADDR_PULSES:     dat_next[7:0] = pulses_reg;
            `ADDR_CONFIG:     dat_next[7:0] = config_reg;
            `ADDR_IRQ_STATUS: dat_next[7:0] = irq_status_reg;
            `ADDR_IRQ_MASK:   dat_next[7:0] = irq_mask_reg;
            `ADDR_CONTROL:    dat_next[0]   = aux_sync;
            default:          dat_next      = 32'h00000000;
        endcase
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_reg         <= overtemp_pkg::idle_st;
            ticks_reg         <= 8'h00;
            seen_reg          <= 1'b0;
            exceeded_done_reg <= 1'b0;
            line_prev_reg     <= 1'b0;
            limit_reg         <= 8'h00;
            pulses_reg        <= `RST_PULSES; // [R8]
            config_reg        <= `RST_CONFIG; // [R16]
            irq_status_reg    <= 8'h00;
            irq_mask_reg      <= 8'h00;
            wb_ack_o          <= 1'b0;
            wb_err_o          <= 1'b0;
            dat_reg           <= 32'h00000000;
        end else begin
            state_reg         <= state_next;
            ticks_reg         <= ticks_next;
            seen_reg          <= seen_next;
            exceeded_done_reg <= exceeded_done_next | exceeded_evt;
            line_prev_reg     <= asserted;
            limit_reg         <= limit_next;
            pulses_reg        <= pulses_next;
            config_reg        <= config_next;
            irq_status_reg    <= irq_status_next;
            irq_mask_reg      <= irq_mask_next;
            wb_ack_o          <= ack_next;
            wb_err_o          <= err_next;
            dat_reg           <= dat_next;
        end
    end
    assign wb_dat_o = dat_reg;
    // per-channel overtemp drive
    logic [2:0] chan_drive;
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : chan_gen
            logic [7:0] lim;
            logic       min_lim;
            assign lim     = channel_limit_i[ch*8 +: 8];
            // [R9] [R15]
            assign min_lim = config_reg[`CFG_TWOS] ? (lim == `LIMIT_TWOS_MIN) : (lim == `LIMIT_OFF64_MIN);
            // [R14]
            assign chan_drive[ch] = config_reg[`CFG_EN_R1 + ch] & ~min_lim & channel_over_limit_i[ch];
        end
    endgenerate
    logic drive_line;
    assign drive_line           = |chan_drive & ~overtemp_global_off_i; // [R17]
    assign overtemp_line_o      = 1'b0;
    assign overtemp_line_oe_n_o = ~drive_line;
    // aux pin: output enabled in general-pin mode with direction bit2 set
    logic aux_out_en;
    assign aux_out_en           = config_reg[`CFG_ID_SEL] & config_reg[`CFG_AUX_DIR]; // [R11] [R13]
    assign aux_pin_six_o        = config_reg[`CFG_AUX_POL] ? aux_pin_value_i : ~aux_pin_value_i; // [R12]
    assign aux_pin_six_oe_n_o   = ~aux_out_en;
    assign aux_pin_six_level_o  = aux_sync;
    assign twos_format_select_o      = config_reg[`CFG_TWOS]; // [R9]
    assign offset_range_select_o     = config_reg[`CFG_OFFSET_RANGE]; // [R10]
    assign id_pins_function_select_o = config_reg[`CFG_ID_SEL]; // [R13]
    assign fan_pulses_per_rev_o      = pulses_reg;
    assign irq_o = |(irq_status_reg & irq_mask_reg);
endmodule : overtemp_timer_fan_config
`default_nettype wire

// [overtemp_timer_fan_config_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module overtemp_timer_fan_config_sva #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        overtemp_line_oe_n_o,
    input wire logic [2:0]  channel_over_limit_i,
    input wire logic [23:0] channel_limit_i,
    input wire logic        lock_i,
    input wire logic        overtemp_global_off_i,
    input wire logic        aux_pin_six_oe_n_o,
    input wire logic        twos_format_select_o,
    input wire logic        offset_range_select_o,
    input wire logic        id_pins_function_select_o,
    input wire logic [7:0]  fan_pulses_per_rev_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic req;
    logic wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    bus_answer_a: assert property (req |=> wb_ack_o != wb_err_o)
        else $error("no single answer");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    unmapped_err_a: assert property (req && !(wb_adr_i inside {8'h42, 8'h43, 8'h44, 8'h79, 8'h7a, 8'h7b,
        8'h7c}) |=> wb_err_o) else $error("unmapped not refused");
    pulses_write_a: assert property (wr && wb_adr_i == 8'h7b |=> fan_pulses_per_rev_o == $past(wb_dat_i[7:0]))
        else $error("pulse field not written");
    config_lock_a: assert property (wr && wb_adr_i == 8'h7c && lock_i |=>
        $stable({twos_format_select_o, offset_range_select_o, id_pins_function_select_o}))
        else $error("locked config changed");
    config_write_a: assert property (wr && wb_adr_i == 8'h7c && !lock_i |=>
        {id_pins_function_select_o, offset_range_select_o, twos_format_select_o} ==
        {$past(wb_dat_i[4]), $past(wb_dat_i[1:0])}) else $error("config bits wrong");
    aux_input_a: assert property (!id_pins_function_select_o |-> aux_pin_six_oe_n_o)
        else $error("aux driven in id mode");
    global_off_a: assert property (overtemp_global_off_i |-> overtemp_line_oe_n_o)
        else $error("line driven while off");
    no_over_a: assert property (channel_over_limit_i == 3'b000 |-> overtemp_line_oe_n_o)
        else $error("line driven without cause");
    min_limit_a: assert property (twos_format_select_o && channel_limit_i == 24'h808080 |->
        overtemp_line_oe_n_o) else $error("line driven at minimum limit");
    cover property (wr && wb_adr_i == 8'h7c && lock_i);
    cover property (!overtemp_line_oe_n_o);
    cover property (wb_err_o);
endmodule : overtemp_timer_fan_config_sva
`default_nettype wire

// [overtemp_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module overtemp_far_side (
    input  wire logic pull_low_i,
    input  wire logic line_oe_n_i,
    input  wire logic aux_oe_n_i,
    input  wire logic aux_dev_i,
    input  wire logic aux_drive_i,
    output logic      line_o,
    output logic      aux_o
);
    // open drain line with pull-up, low when anyone pulls
    assign line_o = !(pull_low_i || !line_oe_n_i);
    assign aux_o = aux_oe_n_i ? aux_drive_i : aux_dev_i;
endmodule : overtemp_far_side
`default_nettype wire

// [test_overtemp_timer_fan_config.sv]
`timescale 1ns/1ps
`default_nettype none
module test_overtemp_timer_fan_config;
    logic clock_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, irq_o;
    logic [7:0] wb_adr_i, fan_pulses_per_rev_o, r;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic overtemp_line_i, overtemp_line_o, overtemp_line_oe_n_o, lock_i, overtemp_global_off_i;
    logic aux_pin_six_i, aux_pin_six_o, aux_pin_six_oe_n_o, aux_pin_value_i, aux_pin_six_level_o;
    logic twos_format_select_o, offset_range_select_o, id_pins_function_select_o, pull_low, aux_far;
    logic [2:0] channel_over_limit_i;
    logic [23:0] channel_limit_i;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    int mismatches, checks, n;
    overtemp_timer_fan_config #(.TICK_CYCLES(10)) i_overtemp_timer_fan_config (.clock_i, .sys_rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
        .overtemp_line_i, .overtemp_line_o, .overtemp_line_oe_n_o, .channel_over_limit_i, .channel_limit_i,
        .lock_i, .overtemp_global_off_i, .aux_pin_six_i, .aux_pin_six_o, .aux_pin_six_oe_n_o,
        .aux_pin_value_i, .twos_format_select_o, .offset_range_select_o, .id_pins_function_select_o,
        .fan_pulses_per_rev_o, .aux_pin_six_level_o, .irq_o);
    overtemp_far_side i_overtemp_far_side (.pull_low_i(pull_low), .line_oe_n_i(overtemp_line_oe_n_o),
        .aux_oe_n_i(aux_pin_six_oe_n_o), .aux_dev_i(aux_pin_six_o), .aux_drive_i(aux_far),
        .line_o(overtemp_line_i), .aux_o(aux_pin_six_i));
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task check(input logic [8:0] seen, input logic [8:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] x);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        exp_q.push_back(x);
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (!(wb_ack_o || wb_err_o) && n < 50);
        if (!(wb_ack_o || wb_err_o)) begin
            mismatches++;
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock_i);
    endtask : bus
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 9'h000);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] v);
        bus(1'b0, a, 8'h00, {1'b0, v});
    endtask : rd
    // read data and refusals checked against the oldest note
    always @(posedge clock_i) begin
        if (wb_ack_o || wb_err_o) begin
            e = exp_q.pop_front();
            check({wb_err_o, (wb_ack_o && !wb_we_i) ? wb_dat_o[7:0] : 8'h00}, e);
        end
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        results();
    end
    initial begin
        r = 8'($urandom(32'hfe4f));
        {sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 12'h001, 32'h0};
        {lock_i, overtemp_global_off_i, aux_pin_value_i, pull_low, aux_far} = 5'h00;
        channel_over_limit_i = 3'b000;
        channel_limit_i = 24'h000000;
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        rd(8'h79, 8'h00);
        rd(8'h7a, 8'h00);
        rd(8'h7b, 8'h55);
        rd(8'h7c, 8'h01);
        bus(1'b0, 8'h50, 8'h00, 9'h100);
        for (int j = 0; j < 4; j++) begin
            wr(8'h7b, {4{j[1:0]}});
            rd(8'h7b, {4{j[1:0]}});
        end
        r = 8'($urandom);
        wr(8'h7a, r);
        rd(8'h7a, r);
        aux_pin_value_i <= 1'($urandom);
        wr(8'h7c, 8'h1e);
        check({5'h00, twos_format_select_o, offset_range_select_o, id_pins_function_select_o,
            aux_pin_six_oe_n_o}, 9'h006);
        check({8'h00, aux_pin_six_o}, {8'h00, aux_pin_value_i});
        wr(8'h7c, 8'h16);
        check({8'h00, aux_pin_six_o}, {8'h00, ~aux_pin_value_i});
        lock_i <= 1'b1;
        wr(8'h7c, 8'h01);
        rd(8'h7c, 8'h16);
        lock_i <= 1'b0;
        wr(8'h43, 8'h21);
        wr(8'h7a, 8'h00);
        pull_low <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(8'h79, 8'h01);
        rd(8'h79, 8'h00);
        check({8'h00, irq_o}, 9'h001);
        rd(8'h42, 8'h21);
        wr(8'h42, 8'h21);
        check({8'h00, irq_o}, 9'h000);
        pull_low <= 1'b0;
        repeat (4) @(posedge clock_i);
        wr(8'h7a, 8'h05);
        pull_low <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(8'h42, 8'h01);
        repeat (60) @(posedge clock_i);
        rd(8'h42, 8'h21);
        rd(8'h79, 8'h07);
        repeat (2600) @(posedge clock_i);
        rd(8'h79, 8'hff);
        wr(8'h43, 8'h00);
        check({8'h00, irq_o}, 9'h000);
        wr(8'h7c, 8'he1);
        channel_limit_i <= {16'h8080, r | 8'h01};
        channel_over_limit_i <= 3'b001;
        @(posedge clock_i);
        check({8'h00, overtemp_line_oe_n_o}, 9'h000);
        overtemp_global_off_i <= 1'b1;
        @(posedge clock_i);
        check({8'h00, overtemp_line_oe_n_o}, 9'h001);
        overtemp_global_off_i <= 1'b0;
        channel_limit_i <= 24'h808080;
        @(posedge clock_i);
        check({8'h00, overtemp_line_oe_n_o}, 9'h001);
        aux_far <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(8'h44, 8'h01);
        check({8'h00, aux_pin_six_level_o}, 9'h001);
        results();
    end
endmodule : test_overtemp_timer_fan_config
bind overtemp_timer_fan_config overtemp_timer_fan_config_sva #(.TICK_CYCLES(TICK_CYCLES))
    i_overtemp_timer_fan_config_sva (.clock_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .overtemp_line_oe_n_o, .channel_over_limit_i,
    .channel_limit_i, .lock_i, .overtemp_global_off_i, .aux_pin_six_oe_n_o, .twos_format_select_o,
    .offset_range_select_o, .id_pins_function_select_o, .fan_pulses_per_rev_o);
`default_nettype wire
